// File: hw/fdr_consts.svh
// Register offsets, field positions and timing counts of the recorder
`ifndef FDR_CONSTS_SVH
`define FDR_CONSTS_SVH
// Notes on behaviour
// - Record length cap is configurable up to 15 s, covering all three spans.
// - Lead and tail intervals are percentages of the length cap.
// - Up to eight selectable signals act as disturbance triggers.
// - Triggers start records only on rising edges; held levels do nothing.
// - A new edge starts a record only after the previous record finished.
// - Every record holds a lead span equal to the lead interval.
// - Event span is min of trigger span and cap minus lead.
// - Remaining tail is min of tail interval and what cap leaves.
// - Recording always stops once the cap has elapsed.
// - Full storage: overwrite oldest if enabled, else halt until cleared.
// - Fault record starts on rising edge of general pickup.
// - General pickup and trip are ORs of all module signals.
// - Measurements latch at trip, optionally after a measurement delay.
// - Trips-only mode drops faults without trip; other mode keeps them.
// - Time-to-trip runs from first pickup to first trip.
// - Time-to-trip is unavailable if pickup and trip modules differ.
// - Fault duration runs from pickup rise to pickup fall.
// - Pickup fall raises a notification showing the newest record.
// - Twenty fault records kept first-in first-out, oldest overwritten.
// - Newest fault record is kept across power loss.
// - Each fault record carries a tripped flag.
// - Settings changed since a record was made are marked modified; only cap, lead, tail and delay writes count here, not control writes.
// - Acknowledge hides notification until restart; clear dismisses it.
// - Fault number counts up on every general pickup.

// Register offsets (byte address = word index times four)
`define FDR_REG_CTRL     8'h00
`define FDR_REG_CAP      8'h04
`define FDR_REG_LEAD     8'h08
`define FDR_REG_TAIL     8'h0C
`define FDR_REG_MDLY     8'h10
`define FDR_REG_STAT     8'h14
`define FDR_REG_FSEL     8'h18
`define FDR_REG_FINFO    8'h1C
`define FDR_REG_FDUR     8'h20
`define FDR_REG_FTTT     8'h24
`define FDR_REG_SETVER   8'h28
// Control fields
`define FDR_CTRL_OVWR    0
`define FDR_CTRL_ALARMS  1
`define FDR_CTRL_DCLR    2
`define FDR_CTRL_ACK     3
`define FDR_CTRL_DISMISS 4
// Timing: one tick of 1 ms
`define FDR_CLK_MHZ      100
`define FDR_TICK_US      1000
`define FDR_TICK_CYC     (`FDR_CLK_MHZ * `FDR_TICK_US)
`define FDR_CAP_MAX_MS   15000
`define FDR_CAP_RST      16'h03E8
`define FDR_PCT_LEAD_RST 8'h0A
`define FDR_PCT_TAIL_RST 8'h14
`define FDR_FAULT_DEPTH  20
`endif

// File: hw/fdr_pkg.sv
// Types of the recorder control
package fdr_pkg;
  typedef enum logic [2:0] {
    FDR_D_IDLE  = 3'b000,
    FDR_D_EVENT = 3'b001,
    FDR_D_TAIL  = 3'b011,
    FDR_D_WRITE = 3'b010,
    FDR_D_HALT  = 3'b110
  } fdr_dstate_t;
endpackage

// File: hw/fdr_fault_store.sv
// Fault record store: twenty entry ring, newest entry separately latched
`timescale 1ns/10ps
`default_nettype none
module fdr_fault_store #(
  parameter int DEPTH = 20,
  parameter int W     = 64
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         wr_i,
  input  wire logic [W-1:0] wdata_i,
  input  wire logic [4:0]   sel_i,
  output logic [W-1:0]      rdata_o,
  output logic [4:0]        count_o,
  output logic [W-1:0]      newest_o
);
  initial begin
    if (DEPTH < 2 || DEPTH > 31) $error("fdr_fault_store: bad DEPTH");
  end
  logic [W-1:0] mem_ff [DEPTH];
  logic [4:0]   wptr_ff;
  logic [4:0]   cnt_ff;
  logic [W-1:0] newest_ff;
  logic [5:0]   idx;

  // Write pointer wraps, so the oldest entry is overwritten
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wptr_ff <= 5'h00;
      cnt_ff  <= 5'h00;
    end else if (wr_i) begin
      wptr_ff <= (wptr_ff == 5'(DEPTH - 1)) ? 5'h00 : wptr_ff + 5'h01;
      if (cnt_ff != 5'(DEPTH)) cnt_ff <= cnt_ff + 5'h01;
    end
  end

  // Entries hold no reset: contents model storage outside the reset domain
  always_ff @(posedge clk_i) begin
    if (wr_i) mem_ff[wptr_ff] <= wdata_i;
  end

  // Newest copy stands for the power-fail-safe slot
  always_ff @(posedge clk_i) begin
    if (wr_i) newest_ff <= wdata_i;
  end

  // Select 0 is the newest, counting back in age
  always_comb begin
    idx = {1'b0, wptr_ff} + 6'(DEPTH) - 6'h01 - {1'b0, sel_i};
    if (idx >= 6'(DEPTH)) idx = idx - 6'(DEPTH);
    if (idx >= 6'(DEPTH)) idx = idx - 6'(DEPTH);
    rdata_o = (sel_i < cnt_ff) ? mem_ff[idx[4:0]] : '0;
  end
  assign count_o  = cnt_ff;
  assign newest_o = newest_ff;
endmodule
`default_nettype wire

// File: hw/fdr_ctrl.sv
// Disturbance and fault recorder control with register port
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "fdr_consts.svh"
module fdr_ctrl #(
  parameter int NTRIG    = 8,
  parameter int NMOD     = 8,
  parameter int SLOTS    = 8,
  parameter int TICK_CYC = `FDR_TICK_CYC
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [7:0]       addr_i,
  input  wire logic [31:0]      wdata_i,
  input  wire logic             wr_i,
  input  wire logic             rd_i,
  output logic [31:0]           rdata_o,
  input  wire logic [NTRIG-1:0] trig_src_i,
  input  wire logic [NMOD-1:0]  pickup_i,
  input  wire logic [NMOD-1:0]  trip_i,
  output logic                  rec_active_o,
  output logic                  rec_lead_o,
  output logic                  rec_event_o,
  output logic                  rec_tail_o,
  output logic                  rec_ready_o,
  output logic                  meas_latch_o,
  output logic                  notify_o,
  output logic [15:0]           fault_no_o
);
  initial begin
    if (NTRIG < 1 || NTRIG > 8) $error("fdr_ctrl: NTRIG 1..8");
    if (NMOD < 1 || NMOD > 8) $error("fdr_ctrl: NMOD 1..8");
    if (TICK_CYC < 1) $error("fdr_ctrl: TICK_CYC");
    if (SLOTS < 1 || SLOTS > 15) $error("fdr_ctrl: SLOTS 1..15");
  end

  // Checks below all run on the one clock and stay quiet in reset
  default clocking chk_cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // First set bit index, used for pickup and trip module ids
  function automatic logic [2:0] first_idx(input logic [7:0] v);
    first_idx = 3'h0;
    for (int k = 7; k >= 0; k--) begin
      if (v[k]) first_idx = 3'(k);
    end
  endfunction

  // Percentage of the cap in ticks
  function automatic logic [15:0] pct_of(input logic [15:0] cap,
                                         input logic [7:0] pct);
    logic [23:0] p;
    p = cap * pct;
    pct_of = 16'(p / 24'h64);
  endfunction

  // Settings registers
  logic [15:0]      cap_ff;
  logic [7:0]       lead_pct_ff, tail_pct_ff;
  logic [15:0]      mdly_ff;
  logic             ovwr_ff, alarms_ff;
  logic [NTRIG-1:0] tsel_ff;
  logic [4:0]       fsel_ff;
  logic [7:0]       setver_ff;
  logic             dclr_ff, ack_ff, dismiss_ff;
  logic             wr_ctrl;
  assign wr_ctrl = wr_i && addr_i == `FDR_REG_CTRL;

  // Software writes; cap clamped to the largest allowed value
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cap_ff <= `FDR_CAP_RST;
      lead_pct_ff <= `FDR_PCT_LEAD_RST;
      tail_pct_ff <= `FDR_PCT_TAIL_RST;
      mdly_ff <= 16'h0000;
      ovwr_ff <= 1'b1;
      alarms_ff <= 1'b1;
      tsel_ff <= '0;
      fsel_ff <= 5'h00;
    end else if (wr_i) begin
      case (addr_i)
        `FDR_REG_CTRL: begin
          ovwr_ff <= wdata_i[`FDR_CTRL_OVWR];
          alarms_ff <= wdata_i[`FDR_CTRL_ALARMS];
          tsel_ff <= wdata_i[8 +: NTRIG];
        end
        `FDR_REG_CAP:
          cap_ff <= (wdata_i[15:0] > 16'(`FDR_CAP_MAX_MS)) ?
                    16'(`FDR_CAP_MAX_MS) : wdata_i[15:0];
        `FDR_REG_LEAD: lead_pct_ff <= (wdata_i[7:0] > 8'h64) ?
                                      8'h64 : wdata_i[7:0];
        `FDR_REG_TAIL: tail_pct_ff <= (wdata_i[7:0] > 8'h64) ?
                                      8'h64 : wdata_i[7:0];
        `FDR_REG_MDLY: mdly_ff <= wdata_i[15:0];
        `FDR_REG_FSEL: fsel_ff <= wdata_i[4:0];
        default: ;
      endcase
    end
  end

  // Command strobes and settings version
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dclr_ff <= 1'b0;
      ack_ff <= 1'b0;
      dismiss_ff <= 1'b0;
      setver_ff <= 8'h00;
    end else begin
      dclr_ff <= wr_ctrl && wdata_i[`FDR_CTRL_DCLR];
      ack_ff <= wr_ctrl && wdata_i[`FDR_CTRL_ACK];
      dismiss_ff <= wr_ctrl && wdata_i[`FDR_CTRL_DISMISS];
      if (wr_i && (addr_i == `FDR_REG_CAP || addr_i == `FDR_REG_LEAD ||
          addr_i == `FDR_REG_TAIL || addr_i == `FDR_REG_MDLY))
        setver_ff <= setver_ff + 8'h01;
    end
  end

  // Fixed timebase tick
  logic [31:0] div_ff;
  logic        tick_ff;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      div_ff <= 32'h0;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= div_ff == 32'(TICK_CYC - 1);
      div_ff <= (div_ff == 32'(TICK_CYC - 1)) ? 32'h0 : div_ff + 32'h1;
    end
  end

  // Trigger edge detection on selected inputs
  logic [NTRIG-1:0] trig_q_ff;
  logic [NTRIG-1:0] trig_rise;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) trig_q_ff <= '0;
    else trig_q_ff <= trig_src_i & tsel_ff;
  end
  assign trig_rise = (trig_src_i & tsel_ff) & ~trig_q_ff;

  // Lead buffer fill: lead span ready once filled
  logic [15:0] lead_t, tail_t, fill_ff;
  assign lead_t = pct_of(cap_ff, lead_pct_ff);
  assign tail_t = pct_of(cap_ff, tail_pct_ff);
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) fill_ff <= 16'h0;
    else if (tick_ff && fill_ff < lead_t) fill_ff <= fill_ff + 16'h1;
  end

  // Disturbance sequencer
  fdr_pkg::fdr_dstate_t dst_ff;
  logic [15:0]      elap_ff, tail_cnt_ff;
  logic [NTRIG-1:0] owner_ff;
  logic [3:0]       used_ff;
  logic             full;
  assign full = used_ff == 4'(SLOTS);
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dst_ff <= fdr_pkg::FDR_D_IDLE;
      elap_ff <= 16'h0;
      tail_cnt_ff <= 16'h0;
      owner_ff <= '0;
      used_ff <= 4'h0;
    end else begin
      if (dclr_ff) used_ff <= 4'h0;
      case (dst_ff)
        fdr_pkg::FDR_D_IDLE:
          if (|trig_rise && fill_ff >= lead_t) begin
            if (full && !ovwr_ff && !dclr_ff)
              dst_ff <= fdr_pkg::FDR_D_HALT;
            else begin
              dst_ff <= fdr_pkg::FDR_D_EVENT;
              owner_ff <= trig_rise;
              elap_ff <= lead_t;
            end
          end
        fdr_pkg::FDR_D_EVENT: begin
          if (tick_ff) elap_ff <= elap_ff + 16'h1;
          if (tick_ff && elap_ff + 16'h1 >= cap_ff)
            dst_ff <= fdr_pkg::FDR_D_WRITE;
          else if (!(|(trig_src_i & owner_ff))) begin
            dst_ff <= fdr_pkg::FDR_D_TAIL;
            tail_cnt_ff <= 16'h0;
          end
        end
        fdr_pkg::FDR_D_TAIL: begin
          if (tick_ff) begin
            elap_ff <= elap_ff + 16'h1;
            tail_cnt_ff <= tail_cnt_ff + 16'h1;
          end
          if (tail_cnt_ff >= tail_t || elap_ff >= cap_ff)
            dst_ff <= fdr_pkg::FDR_D_WRITE;
        end
        fdr_pkg::FDR_D_WRITE: begin
          dst_ff <= fdr_pkg::FDR_D_IDLE;
          if (!full && !dclr_ff) used_ff <= used_ff + 4'h1;
        end
        fdr_pkg::FDR_D_HALT:
          if (dclr_ff) dst_ff <= fdr_pkg::FDR_D_IDLE;
        default: dst_ff <= fdr_pkg::FDR_D_IDLE;
      endcase
    end
  end

  // Recording phase outputs
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rec_active_o <= 1'b0;
      rec_lead_o <= 1'b0;
      rec_event_o <= 1'b0;
      rec_tail_o <= 1'b0;
      rec_ready_o <= 1'b0;
    end else begin
      rec_event_o <= dst_ff == fdr_pkg::FDR_D_EVENT;
      rec_tail_o <= dst_ff == fdr_pkg::FDR_D_TAIL;
      rec_active_o <= dst_ff == fdr_pkg::FDR_D_EVENT ||
                      dst_ff == fdr_pkg::FDR_D_TAIL;
      rec_lead_o <= dst_ff == fdr_pkg::FDR_D_IDLE && |trig_rise &&
                    fill_ff >= lead_t && !(full && !ovwr_ff && !dclr_ff);
      rec_ready_o <= dst_ff == fdr_pkg::FDR_D_IDLE && fill_ff >= lead_t;
    end
  end

  // General pickup and trip
  logic gp, gt, gp_q_ff, in_fault_ff, tripped_ff;
  assign gp = |pickup_i;
  assign gt = |trip_i;
  logic [15:0] dur_ff, ttt_ff, mcnt_ff;
  logic [2:0]  pk_mod_ff;
  logic        ttt_ok_ff, mpend_ff;
  logic        fault_wr;
  logic [63:0] fault_rec, rd_rec, newest;
  logic [4:0]  fcount;

  // Fault window and timing
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      gp_q_ff <= 1'b0;
      in_fault_ff <= 1'b0;
      tripped_ff <= 1'b0;
      dur_ff <= 16'h0;
      ttt_ff <= 16'h0;
      pk_mod_ff <= 3'h0;
      ttt_ok_ff <= 1'b0;
      fault_no_o <= 16'h0;
    end else begin
      gp_q_ff <= gp;
      if (gp && !gp_q_ff) begin
        in_fault_ff <= 1'b1;
        tripped_ff <= 1'b0;
        dur_ff <= 16'h0;
        ttt_ff <= 16'h0;
        ttt_ok_ff <= 1'b0;
        pk_mod_ff <= first_idx(8'(pickup_i));
        fault_no_o <= fault_no_o + 16'h1;
      end else if (in_fault_ff) begin
        if (tick_ff) dur_ff <= dur_ff + 16'h1;
        if (tick_ff && !tripped_ff) ttt_ff <= ttt_ff + 16'h1;
        if (gt && !tripped_ff) begin
          tripped_ff <= 1'b1;
          ttt_ok_ff <= first_idx(8'(trip_i)) == pk_mod_ff;
        end
        if (!gp) in_fault_ff <= 1'b0;
      end
    end
  end

  // Measurement latch at trip, after the set delay
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mpend_ff <= 1'b0;
      mcnt_ff <= 16'h0;
      meas_latch_o <= 1'b0;
    end else begin
      meas_latch_o <= 1'b0;
      if (in_fault_ff && gt && !tripped_ff) begin
        mpend_ff <= 1'b1;
        mcnt_ff <= 16'h0;
      end else if (mpend_ff) begin
        if (mcnt_ff >= mdly_ff) begin
          mpend_ff <= 1'b0;
          meas_latch_o <= 1'b1;
        end else if (tick_ff) mcnt_ff <= mcnt_ff + 16'h1;
      end
    end
  end

  // Record stored at pickup fall; trips-only drops untripped
  assign fault_wr = in_fault_ff && !gp && (tripped_ff || alarms_ff);
  assign fault_rec = {setver_ff, tripped_ff, ttt_ok_ff, 3'h0, pk_mod_ff,
                      fault_no_o, ttt_ff, dur_ff};

  fdr_fault_store #(.DEPTH(`FDR_FAULT_DEPTH), .W(64)) u_store (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .wr_i    (fault_wr),
    .wdata_i (fault_rec),
    .sel_i   (fsel_ff),
    .rdata_o (rd_rec),
    .count_o (fcount),
    .newest_o(newest)
  );

  // Notification: raised on record, acknowledge hides
  logic dismissed_ff;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      notify_o <= 1'b0;
      dismissed_ff <= 1'b0;
    end else if (fault_wr) begin
      notify_o <= 1'b1;  // set wins over clear
      dismissed_ff <= 1'b0;
    end else if (dismiss_ff) begin
      notify_o <= 1'b0;
      dismissed_ff <= 1'b1;
    end else if (ack_ff) notify_o <= 1'b0;
  end

  // Read mux, data the cycle after the read strobe
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) rdata_o <= 32'h0;
    else if (rd_i) begin
      case (addr_i)
        `FDR_REG_CTRL: rdata_o <= {16'h0, 8'(tsel_ff), 6'h0,
                                   alarms_ff, ovwr_ff};
        `FDR_REG_CAP: rdata_o <= {16'h0, cap_ff};
        `FDR_REG_LEAD: rdata_o <= {24'h0, lead_pct_ff};
        `FDR_REG_TAIL: rdata_o <= {24'h0, tail_pct_ff};
        `FDR_REG_MDLY: rdata_o <= {16'h0, mdly_ff};
        `FDR_REG_STAT: rdata_o <= {fcount, dismissed_ff, notify_o,
                                   in_fault_ff, used_ff, 17'h0, dst_ff};
        `FDR_REG_FSEL: rdata_o <= {27'h0, fsel_ff};
        `FDR_REG_FINFO: rdata_o <= (fsel_ff == 5'h00) ? newest[63:32] :
                                   rd_rec[63:32];
        `FDR_REG_FDUR: rdata_o <= {16'h0, rd_rec[15:0]};
        `FDR_REG_FTTT: rdata_o <= {15'h0, rd_rec[54], rd_rec[31:16]};
        `FDR_REG_SETVER: rdata_o <= {23'h0,
          rd_rec[63:56] != setver_ff, setver_ff};
        default: rdata_o <= 32'h0;
      endcase
    end
  end

  // Checks, on the default clock and reset declared at the top
  a_edge_only: assert property (
    rec_lead_o |-> $past(|trig_rise)) else $error("start without edge");
  a_cap_bound: assert property (
    rec_active_o |-> elap_ff <= cap_ff + 16'h1) else $error("cap passed");
  a_no_start_busy: assert property (
    rec_lead_o |-> !rec_active_o) else $error("restart mid record");
  a_gp_count: assert property (
    (gp && !gp_q_ff) |=> fault_no_o == $past(fault_no_o) + 16'h1)
    else $error("fault number");
  a_trips_only: assert property (
    (fault_wr && !alarms_ff) |-> tripped_ff) else $error("untripped kept");
  a_notify_rise: assert property (
    fault_wr |=> notify_o) else $error("no notification");
  a_halt_full: assert property (
    dst_ff == fdr_pkg::FDR_D_HALT |-> full) else $error("halt not full");
  a_fifo_max: assert property (
    fcount <= 5'h14) else $error("store over");
  c_record: cover property (dst_ff == fdr_pkg::FDR_D_TAIL);
  c_fault: cover property (fault_wr && tripped_ff);
  c_halt: cover property (dst_ff == fdr_pkg::FDR_D_HALT);
endmodule
`default_nettype wire

// File: sim/fdr_prot_model.sv
// Protection module model: pickup and trip levels of eight modules
`timescale 1ns/10ps
`default_nettype none
module fdr_prot_model (
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [2:0] pm_i,
  input  wire logic [2:0] tm_i,
  input  wire logic       trip_en_i,
  input  wire logic [7:0] tdly_i,
  input  wire logic [7:0] dur_i,
  // Quiet modules until the first fault; one process drives each output
  output logic [7:0]      pickup_o = 8'h00,
  output logic [7:0]      trip_o   = 8'h00,
  output logic            busy_o   = 1'b0
);
  logic [7:0] cnt_ff = 8'h00;

  // One fault: first pickup, second module, optional trip, drop-out
  always @(posedge clk_i) begin
    if (go_i && !busy_o) begin
      busy_o         <= 1'b1;
      cnt_ff         <= 8'h00;
      pickup_o[pm_i] <= 1'b1;
    end else if (busy_o) begin
      cnt_ff <= cnt_ff + 8'h01;
      // Tripping module may differ from the starting one
      if (cnt_ff == 8'h02) pickup_o[tm_i] <= 1'b1;
      if (cnt_ff == tdly_i && trip_en_i) trip_o[tm_i] <= 1'b1;
      // Pickup and trip drop together, so the fault ends cleanly
      if (cnt_ff == dur_i) begin
        pickup_o <= 8'h00;
        trip_o   <= 8'h00;
        busy_o   <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: sim/test_fdr_ctrl.sv
// Self-checking bench of the recorder control
`timescale 1ns/10ps
`default_nettype none
`include "fdr_consts.svh"
module test_fdr_ctrl;
  localparam int T = 4;
  logic        clk, rst_n, wr, rd, go, te, rd_seen;
  logic        act, lead, evt, tail, rdy, meas, ntf, busy;
  logic [7:0]  addr, trig, pk, tp, tdly, dur;
  logic [2:0]  pm, tm;
  logic [15:0] fno;
  logic [31:0] wdata, rdata, ctrl;
  logic [31:0] eq[$];
  logic [31:0] mq[$];
  string       nq[$];
  int          error_cnt, n_checks, nlead, nmeas, ev_len, tl_len;
  int          expno, nrec, l0;

  // Short tick keeps the spans to a few dozen cycles
  fdr_ctrl #(.TICK_CYC(T)) fdr_ctrl_i (
    .clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .trig_src_i(trig),
    .pickup_i(pk), .trip_i(tp), .rec_active_o(act), .rec_lead_o(lead),
    .rec_event_o(evt), .rec_tail_o(tail), .rec_ready_o(rdy),
    .meas_latch_o(meas), .notify_o(ntf), .fault_no_o(fno));

  fdr_prot_model fdr_prot_model_i (
    .clk_i(clk), .go_i(go), .pm_i(pm), .tm_i(tm), .trip_en_i(te),
    .tdly_i(tdly), .dur_i(dur), .pickup_o(pk), .trip_o(tp),
    .busy_o(busy));

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Watchdog, far beyond the expected run of a few thousand cycles
  initial begin
    #400000;
    error_cnt++;
    conclude();
  end

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rng(string n, int lo, int hi, int v);
    n_checks++;
    if (v < lo || v > hi) begin
      error_cnt++;
      $display("Error %s expected %0d..%0d seen %0d", n, lo, hi, v);
    end
  endtask

  task automatic bw(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read: the expectation waits in the queue for the data cycle
  task automatic br(logic [7:0] a, logic [31:0] e, logic [31:0] m,
                    string n);
    @(posedge clk);
    {addr, rd} <= {a, 1'b1};
    eq.push_back(e & m);
    mq.push_back(m);
    nq.push_back(n);
    @(posedge clk);
    rd <= 1'b0;
  endtask

  // Read data appear in the cycle after the strobe and hold until the next read
  always @(posedge clk) rd_seen <= rd;
  always @(negedge clk) begin
    if (rd_seen === 1'b1)
      chk(nq.pop_front(), eq.pop_front(), rdata & mq.pop_front());
  end

  // Record starts, span lengths and measurement latches
  always @(posedge clk) begin
    if (meas === 1'b1) nmeas <= nmeas + 1;
    if (lead === 1'b1) begin
      nlead  <= nlead + 1;
      ev_len <= 0;
      tl_len <= 0;
    end else begin
      if (evt === 1'b1) ev_len <= ev_len + 1;
      if (tail === 1'b1) tl_len <= tl_len + 1;
    end
  end

  task automatic fault(logic [2:0] p, logic [2:0] t, logic e,
                       logic [7:0] d);
    int   m0;
    logic r;
    m0 = nmeas;
    r  = e | ctrl[1];
    @(posedge clk);
    {pm, tm, te, tdly, dur, go} <= {p, t, e, d, d + 8'h18, 1'b1};
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 300 && busy === 1'b1; i++) @(posedge clk);
    repeat (3) @(posedge clk);
    @(negedge clk);
    expno++;
    chk("fault number", 32'(expno), 32'(fno));
    chk("latch count", 32'(e), 32'(nmeas - m0));
    if (r) begin
      nrec = (nrec < 20) ? nrec + 1 : 20;
      chk("notify", 32'h1, 32'(ntf));
      br(`FDR_REG_FINFO, {8'h00, e, e & (p == t), 3'h0, p, expno[15:0]},
         32'h00C7FFFF, "fault info");
      // Read data still stand at the falling edge after the read task
      br(`FDR_REG_FTTT, {15'h0, e & (p == t), 16'h0}, 32'hFFFF0000,
         "ttt valid");
      @(negedge clk);
      if (e)
        rng("time to trip", d / 4 - 1, d / 4 + 2, rdata[15:0]);
      br(`FDR_REG_FDUR, 32'h0, 32'hFFFF0000, "duration high");
      @(negedge clk);
      rng("fault duration", d / 4 + 5, d / 4 + 8, rdata[15:0]);
      bw(`FDR_REG_CTRL, ctrl | 32'h8);
      // Acknowledge strobe is registered, so notify drops a cycle later
      repeat (2) @(negedge clk);
      chk("acknowledge", 32'h0, 32'(ntf));
    end
    br(`FDR_REG_STAT, 32'(nrec) << 27, 32'hF8000000, "count");
  endtask

  task automatic waitr();
    @(posedge clk);
    for (int i = 0; i < 400 && rdy !== 1'b1; i++) @(posedge clk);
  endtask

  task automatic pulse(int b, int n);
    @(posedge clk);
    trig[b] <= 1'b1;
    repeat (n) @(posedge clk);
    trig[b] <= 1'b0;
  endtask

  // Wait out the spans and the store write
  task automatic settle();
    for (int i = 0; i < 300 && act === 1'b1; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    // Counters are two-state and start at zero in their own processes
    {rst_n, wr, rd, go, te, pm, tm} = '0;
    {addr, trig, tdly, dur, wdata, ctrl} = '0;
    void'($urandom(32'h11E66378));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    br(`FDR_REG_CAP, `FDR_CAP_RST, 32'hFFFF, "cap reset");
    br(`FDR_REG_LEAD, `FDR_PCT_LEAD_RST, 32'hFF, "lead reset");
    br(`FDR_REG_TAIL, `FDR_PCT_TAIL_RST, 32'hFF, "tail reset");
    br(8'h3C, 32'h0, 32'hFFFFFFFF, "unmapped");
    bw(`FDR_REG_CAP, 32'h4E20);
    bw(`FDR_REG_LEAD, 32'h96);
    br(`FDR_REG_CAP, `FDR_CAP_MAX_MS, 32'hFFFF, "cap clamp");
    br(`FDR_REG_LEAD, 32'h64, 32'hFF, "lead clamp");
    // Cap 20 ticks: lead 2 ticks, tail 4 ticks
    bw(`FDR_REG_CAP, 32'h14);
    bw(`FDR_REG_LEAD, 32'h0A);
    bw(`FDR_REG_MDLY, 32'h2);
    $display("test registers done");
    // Trips-only first, then alarms and trips
    ctrl = 32'h0301;
    bw(`FDR_REG_CTRL, ctrl);
    fault(3'h1, 3'h1, 1'b0, 8'h10);
    fault(3'h2, 3'h2, 1'b1, 8'h10);
    ctrl = 32'h0303;
    bw(`FDR_REG_CTRL, ctrl);
    fault(3'h4, 3'h5, 1'b0, 8'h10);
    fault(3'h1, 3'h6, 1'b1, 8'h12);
    for (int k = 0; k < 20; k++)
      fault(3'($urandom), 3'($urandom), 1'($urandom),
            8'h08 + 8'($urandom % 32));
    $display("test faults done");
    // Short trigger: event follows the trigger, full tail follows
    bw(`FDR_REG_CTRL, ctrl | 32'h4);
    waitr();
    chk("ready", 32'h1, 32'(rdy));
    l0 = nlead;
    pulse(0, 20);
    settle();
    chk("idle after", 32'h0, 32'(act));
    chk("record start", 32'(l0 + 1), 32'(nlead));
    rng("event span", 16, 28, ev_len);
    rng("tail span", 12, 20, tl_len);
    // Held trigger: cut at cap minus lead, no tail, no retrigger
    waitr();
    trig[0] <= 1'b1;
    repeat (10) @(posedge clk);
    settle();
    rng("capped event", 64, 76, ev_len);
    chk("no tail", 32'h0, 32'(tl_len));
    repeat (100) @(posedge clk);
    chk("held level", 32'(l0 + 2), 32'(nlead));
    trig[1] <= 1'b1;
    repeat (10) @(posedge clk);
    settle();
    chk("other edge", 32'(l0 + 3), 32'(nlead));
    pulse(2, 8);
    repeat (20) @(posedge clk);
    chk("unselected", 32'(l0 + 3), 32'(nlead));
    trig <= 8'h00;
    $display("test disturbance done");
    // Overwrite off: ninth record refused until cleared
    ctrl = 32'h0302;
    bw(`FDR_REG_CTRL, ctrl | 32'h4);
    l0 = nlead;
    repeat (9) begin
      waitr();
      pulse(1, 4);
      settle();
    end
    chk("full store", 32'(l0 + 8), 32'(nlead));
    br(`FDR_REG_STAT, {8'h00, 4'h8, 17'h0, fdr_pkg::FDR_D_HALT},
       32'h00F00007, "halted");
    bw(`FDR_REG_CTRL, ctrl | 32'h4);
    waitr();
    pulse(1, 4);
    settle();
    chk("after clear", 32'(l0 + 9), 32'(nlead));
    $display("test storage done");
    conclude();
  end
endmodule
`default_nettype wire
